// >>> design/mddr_regs.sv
// motion drive data register bank with move state tracking
// assumes motion engine values and events synchronous to clock_i
`timescale 1ns/1ps
`include "mddr_cfg.svh"
module mddr_regs (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // host register requests
  input wire logic req_valid_i,
  input wire mddr_pkg::mddr_req_t req_i,
  output logic req_ready_o,
  // host answers
  output logic rsp_valid_o,
  output logic rsp_err_o,
  output logic rsp_neg_o,
  output logic [39:0] rsp_digits_o,
  output logic [31:0] rsp_value_o,
  // motion engine values
  input wire mddr_pkg::mddr_status_t stat_i,
  input wire logic stepper_i,
  input wire logic stall_en_i,
  input wire logic [7:0] top_in_closed_i,
  input wire logic [3:0] drv_out_closed_i,
  input wire logic exp_board_i,
  // set position command
  input wire logic set_pos_valid_i,
  input wire logic [31:0] set_pos_i,
  // flag events, one bit per flag
  input wire logic [3:0] flag_event_i,
  // move progress from the trajectory engine
  input wire logic move_start_i,
  input wire logic brake_released_i,
  input wire logic calc_done_i,
  input wire logic at_speed_i,
  input wire logic speed_change_i,
  input wire logic decel_start_i,
  input wire logic stop_i,
  input wire logic stopped_i,
  // settings to the trajectory engine
  output logic [15:0] accel_rate_o,
  output logic [15:0] decel_rate_o,
  output logic [31:0] change_dist_o,
  output logic [31:0] move_dist_o,
  output logic [3:0] move_state_o
);
  localparam logic [11:0] CLEAN_LAST = 12'(`MDDR_PWM_CYC - 1);

  mddr_pkg::mddr_move_t state_ff;    // move state
  mddr_pkg::mddr_move_t nxt_state;   // next move state
  logic [11:0] clean_cnt_ff;         // cycles spent in cleanup
  logic [31:0] user_ff [`MDDR_USER_CNT]; // accumulator and user regs
  logic [31:0] pos_off_ff;           // position offset
  logic [31:0] set_pos_ff;           // last set position
  logic [3:0] flags_ff;              // sticky other flags
  logic [15:0] tgt_vel_ff;           // held target velocity
  logic busy_ff;                     // request in conversion
  logic err_ff;                      // error of current request
  logic conv_start_ff;               // start pulse to converter
  logic [31:0] conv_val_ff;          // value to convert
  logic [3:0] nxt_code;              // move code of next state
  logic [15:0] exp_w;                // expanded inputs word
  logic take;                        // request accepted
  logic [31:0] rd_a;                 // first operand read
  logic [31:0] rd_b;                 // second operand read
  logic hit_a;                       // first address mapped
  logic hit_b;                       // second address mapped
  logic is_user;                     // target is a user register
  logic is_rw;                       // target is writable
  logic wr_en;                       // host write strobe
  logic [31:0] and_res;              // register and result
  logic [15:0] acc_scaled;           // scaled accel/decel command
  logic flg_wr;                      // host write to other flags
  logic [31:0] conv_val;             // converter operand
  logic op_err;                      // request error
  logic conv_done;                   // converter finished

  // request handshake and decode
  assign take = req_valid_i && req_ready_o;
  assign is_user = req_i.addr <= `MDDR_USER_LAST;
  assign is_rw = is_user || (req_i.addr >= `MDDR_ACCEL_RATE &&
                 req_i.addr <= `MDDR_OTHER_FLAGS);
  assign wr_en = take && req_i.op == `MDDR_OP_WRITE && is_rw;
  assign flg_wr = wr_en && req_i.addr == `MDDR_OTHER_FLAGS;
  assign and_res = rd_a & rd_b;
  assign acc_scaled = 16'(req_i.data[15:0] * `MDDR_ACC_SCALE);

  // expanded inputs: io bits are one when open, bits 14:12 unused, bit 15 is the expansion board bit
  assign exp_w[`MDDR_EXP_IN_LSB +: 8] = ~top_in_closed_i;
  assign exp_w[`MDDR_EXP_OUT_LSB +: 4] = ~drv_out_closed_i;
  assign exp_w[14:12] = 3'h0;
  assign exp_w[`MDDR_EXP_ID_BIT] = exp_board_i;

  // move code for a state, zero where the state is undefined
  function automatic logic [3:0] code_of(mddr_pkg::mddr_move_t s);
    logic [3:0] c;
    c = `MDDR_MS_UNDEF;
    case (s)
      mddr_pkg::MS_WAIT: c = `MDDR_MS_WAIT;
      mddr_pkg::MS_CALC: c = `MDDR_MS_CALC;
      mddr_pkg::MS_ACCEL: c = `MDDR_MS_ACCEL;
      mddr_pkg::MS_CHANGE: c = `MDDR_MS_CHANGE;
      mddr_pkg::MS_ATSPD: c = `MDDR_MS_ATSPD;
      mddr_pkg::MS_DECEL: c = `MDDR_MS_DECEL;
      mddr_pkg::MS_FAST: c = `MDDR_MS_FAST;
      mddr_pkg::MS_CLEAN: c = `MDDR_MS_CLEAN;
      default: c = `MDDR_MS_UNDEF;
    endcase
    return c;
  endfunction
  assign nxt_code = code_of(nxt_state);

  // register read, 16-bit registers sign extend as integers
  function automatic logic [32:0] read_reg(logic [7:0] a);
    logic [32:0] r;
    r = 33'h0;
    if (a <= `MDDR_USER_LAST) begin
      r = {1'b1, user_ff[a[3:0]]};
    end else if (a == `MDDR_ACCEL_RATE) begin
      r = {1'b1, {16{accel_rate_o[15]}}, accel_rate_o};
    end else if (a == `MDDR_DECEL_RATE) begin
      r = {1'b1, {16{decel_rate_o[15]}}, decel_rate_o};
    end else if (a == `MDDR_CHANGE_DIST) begin
      r = {1'b1, change_dist_o};
    end else if (a == `MDDR_MOVE_DIST) begin
      r = {1'b1, move_dist_o};
    end else if (a == `MDDR_POS_OFFSET) begin
      r = {1'b1, pos_off_ff};
    end else if (a == `MDDR_OTHER_FLAGS) begin
      r = {1'b1, 28'h0, flags_ff};
    end else if (a == `MDDR_MOVE_STATE) begin
      r = {1'b1, 28'h0, move_state_o};
    end else if (a == `MDDR_SEGMENT) begin
      r = {1'b1, {16{stat_i.segment[15]}}, stat_i.segment};
    end else if (a == `MDDR_CURRENT) begin
      r = {1'b1, {16{stat_i.current[15]}}, stat_i.current};
    end else if (a == `MDDR_CLAMP_PWR) begin
      r = {1'b1, {16{stat_i.clamp_pwr[15]}}, stat_i.clamp_pwr};
    end else if (a == `MDDR_STATUS_CODE) begin
      r = {1'b1, {16{stat_i.status_code[15]}}, stat_i.status_code};
    end else if (a == `MDDR_TEMPERATURE) begin
      r = {1'b1, {16{stat_i.temperature[15]}}, stat_i.temperature};
    end else if (a == `MDDR_BUS_VOLT) begin
      r = {1'b1, {16{stat_i.bus_volt[15]}}, stat_i.bus_volt};
    end else if (a == `MDDR_ACT_VEL) begin
      // quarter rpm units straight from the engine
      r = {1'b1, {16{stat_i.act_vel[15]}}, stat_i.act_vel};
    end else if (a == `MDDR_TGT_VEL) begin
      r = {1'b1, {16{tgt_vel_ff[15]}}, tgt_vel_ff};
    end else if (a == `MDDR_POS_ERR) begin
      r = {1'b1, stat_i.pos_err};
    end else if (a == `MDDR_EXP_INPUTS) begin
      r = {1'b1, {16{exp_w[15]}}, exp_w};
    end else if (a == `MDDR_PHASE_ERR) begin
      r = {1'b1, {16{stat_i.phase_err[15]}}, stat_i.phase_err};
    end
    return r;
  endfunction
  // process form so that changes inside the mapped registers wake the read
  always_comb {hit_a, rd_a} = read_reg(req_i.addr);
  always_comb {hit_b, rd_b} = read_reg(req_i.addr_b);

  // value echoed and converted for each op; integer only
  always_comb begin
    conv_val = rd_a;
    op_err = !hit_a;
    if (req_i.op == `MDDR_OP_WRITE) begin
      conv_val = req_i.data;
      op_err = !is_rw;
    end else if (req_i.op == `MDDR_OP_AND) begin
      conv_val = and_res;
      op_err = !hit_a || !hit_b;
    end else if (req_i.op == `MDDR_OP_ACCEL || req_i.op == `MDDR_OP_DECEL) begin
      conv_val = {16'h0, acc_scaled};
      op_err = 1'b0;
    end else if (req_i.op != `MDDR_OP_READ) begin
      op_err = 1'b1;
    end
  end

  // point-to-point move sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      mddr_pkg::MS_IDLE: if (move_start_i) nxt_state = mddr_pkg::MS_WAIT;
      mddr_pkg::MS_WAIT: begin
        if (stop_i) nxt_state = mddr_pkg::MS_FAST;
        else if (brake_released_i) nxt_state = mddr_pkg::MS_CALC;
      end
      mddr_pkg::MS_CALC: begin
        if (stop_i) nxt_state = mddr_pkg::MS_FAST;
        else if (calc_done_i) nxt_state = mddr_pkg::MS_ACCEL;
      end
      mddr_pkg::MS_ACCEL, mddr_pkg::MS_CHANGE: begin
        if (stop_i) nxt_state = mddr_pkg::MS_FAST;
        else if (decel_start_i) nxt_state = mddr_pkg::MS_DECEL;
        else if (at_speed_i) nxt_state = mddr_pkg::MS_ATSPD;
      end
      mddr_pkg::MS_ATSPD: begin
        if (stop_i) nxt_state = mddr_pkg::MS_FAST;
        else if (decel_start_i) nxt_state = mddr_pkg::MS_DECEL;
        else if (speed_change_i) nxt_state = mddr_pkg::MS_CHANGE;
      end
      mddr_pkg::MS_DECEL: begin
        if (stop_i) nxt_state = mddr_pkg::MS_FAST;
        else if (stopped_i) nxt_state = mddr_pkg::MS_CLEAN;
      end
      mddr_pkg::MS_FAST: if (stopped_i) nxt_state = mddr_pkg::MS_CLEAN;
      mddr_pkg::MS_CLEAN: begin
        // leave after one full pwm cycle
        if (clean_cnt_ff == CLEAN_LAST) nxt_state = mddr_pkg::MS_IDLE;
      end
      default: nxt_state = mddr_pkg::MS_IDLE;
    endcase
  end

  // move state and cleanup counter
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= mddr_pkg::MS_IDLE;
      clean_cnt_ff <= 12'h000;
      move_state_o <= `MDDR_MS_UNDEF;
    end else begin
      state_ff <= nxt_state;
      move_state_o <= nxt_code;
      clean_cnt_ff <= (state_ff == mddr_pkg::MS_CLEAN) ?
                      clean_cnt_ff + 12'h001 : 12'h000;
    end
  end

  // read/write data registers
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      accel_rate_o <= 16'h0000;
      decel_rate_o <= 16'h0000;
      change_dist_o <= 32'h0;
      move_dist_o <= 32'h0;
    end else begin
      if (wr_en && req_i.addr == `MDDR_ACCEL_RATE) accel_rate_o <= req_i.data[15:0];
      else if (take && req_i.op == `MDDR_OP_ACCEL) accel_rate_o <= acc_scaled;
      if (wr_en && req_i.addr == `MDDR_DECEL_RATE) decel_rate_o <= req_i.data[15:0];
      else if (take && req_i.op == `MDDR_OP_DECEL) decel_rate_o <= acc_scaled;
      if (wr_en && req_i.addr == `MDDR_CHANGE_DIST) change_dist_o <= req_i.data;
      if (wr_en && req_i.addr == `MDDR_MOVE_DIST) move_dist_o <= req_i.data;
    end
  end

  // accumulator and user registers
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < `MDDR_USER_CNT; i++) user_ff[i] <= 32'h0;
    end else if (take && req_i.op == `MDDR_OP_AND && hit_a && hit_b) begin
      user_ff[0] <= and_res;
    end else if (wr_en && is_user) begin
      user_ff[req_i.addr[3:0]] <= req_i.data;
    end
  end

  // position offset tracks encoder minus set position
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      set_pos_ff <= 32'h0;
      pos_off_ff <= 32'h0;
    end else if (wr_en && req_i.addr == `MDDR_POS_OFFSET) begin
      set_pos_ff <= stat_i.enc_pos - req_i.data;
      pos_off_ff <= req_i.data;
    end else begin
      if (set_pos_valid_i) set_pos_ff <= set_pos_i;
      pos_off_ff <= stat_i.enc_pos - set_pos_ff;
    end
  end

  // sticky flags, a new event wins over a host clear
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_ff <= 4'h0;
    end else if (flg_wr) begin
      flags_ff <= req_i.data[3:0] | flag_event_i;
    end else begin
      flags_ff <= flags_ff | flag_event_i;
    end
  end

  // target velocity hold for steppers without stall logic
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tgt_vel_ff <= 16'h0000;
    end else if (!stepper_i || stall_en_i) begin
      tgt_vel_ff <= stat_i.tgt_vel;
    end
  end

  // request tracking and answer error
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_ff <= 1'b0;
      err_ff <= 1'b0;
      conv_start_ff <= 1'b0;
      conv_val_ff <= 32'h0;
      req_ready_o <= 1'b0;
      rsp_err_o <= 1'b0;
    end else begin
      conv_start_ff <= take;
      req_ready_o <= !busy_ff && !take && !conv_done;
      if (take) begin
        busy_ff <= 1'b1;
        err_ff <= op_err;
        conv_val_ff <= op_err ? 32'h0 : conv_val;
      end else if (conv_done) begin
        busy_ff <= 1'b0;
        rsp_err_o <= err_ff;
      end
    end
  end

  // decimal answer
  mddr_bin2dec u_dec (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .start_i(conv_start_ff),
    .value_i(conv_val_ff),
    .done_o(conv_done),
    .neg_o(rsp_neg_o),
    .digits_o(rsp_digits_o),
    .value_o(rsp_value_o)
  );
  assign rsp_valid_o = conv_done;

  // checks
  AST_UNDEF_OUTSIDE: assert property (@(posedge clock_i) disable iff (!nrst_i)
    state_ff == mddr_pkg::MS_IDLE |=> move_state_o == 4'h0 ||
    $past(move_start_i)) else $error("move state set outside move");
  AST_CODE_MATCH: assert property (@(posedge clock_i) disable iff (!nrst_i)
    1'b1 |=> move_state_o == code_of(state_ff))
    else $error("move code does not match state");
  AST_CLEAN_LEN: assert property (@(posedge clock_i) disable iff (!nrst_i)
    state_ff == mddr_pkg::MS_CLEAN && clean_cnt_ff != CLEAN_LAST |=>
    state_ff == mddr_pkg::MS_CLEAN)
    else $error("cleanup left early");
  AST_CLEAN_EXIT: assert property (@(posedge clock_i) disable iff (!nrst_i)
    state_ff == mddr_pkg::MS_CLEAN && clean_cnt_ff == CLEAN_LAST |=>
    state_ff == mddr_pkg::MS_IDLE)
    else $error("cleanup overstayed");
  AST_CLEAN_CNT: assert property (@(posedge clock_i) disable iff (!nrst_i)
    state_ff == mddr_pkg::MS_CLEAN |-> clean_cnt_ff <= CLEAN_LAST)
    else $error("cleanup overran");
  AST_TGT_HOLD: assert property (@(posedge clock_i) disable iff (!nrst_i)
    stepper_i && !stall_en_i |=> $stable(tgt_vel_ff))
    else $error("target velocity moved without stall");
  AST_EXP_WORD: assert property (@(posedge clock_i) disable iff (!nrst_i)
    take && req_i.op == `MDDR_OP_READ && req_i.addr == `MDDR_EXP_INPUTS
    |=> conv_val_ff[15:0] == {$past(exp_board_i), 3'h0,
    ~$past(drv_out_closed_i), ~$past(top_in_closed_i)})
    else $error("expanded inputs layout wrong");
  AST_AND_ACC: assert property (@(posedge clock_i) disable iff (!nrst_i)
    take && req_i.op == `MDDR_OP_AND && hit_a && hit_b
    |=> user_ff[0] == $past(and_res)) else $error("and result lost");
  AST_ACC_SCALE: assert property (@(posedge clock_i) disable iff (!nrst_i)
    take && req_i.op == `MDDR_OP_ACCEL |=>
    accel_rate_o == 16'($past(req_i.data[15:0]) * 16'h0006))
    else $error("accel scale wrong");
  AST_DEC_SCALE: assert property (@(posedge clock_i) disable iff (!nrst_i)
    take && req_i.op == `MDDR_OP_DECEL |=>
    decel_rate_o == 16'($past(req_i.data[15:0]) * 16'h0006))
    else $error("decel scale wrong");
  AST_OFFSET: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !wr_en ##1 !$past(wr_en) |-> pos_off_ff ==
    $past(stat_i.enc_pos) - $past(set_pos_ff)) else $error("offset wrong");
  AST_FLAG_STICK: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !flg_wr |=> (flags_ff & $past(flags_ff | flag_event_i)) ==
    $past(flags_ff | flag_event_i)) else $error("flag dropped");
  AST_FLAG_CLR: assert property (@(posedge clock_i) disable iff (!nrst_i)
    flg_wr && req_i.data[3:0] == 4'h0 |=> flags_ff == $past(flag_event_i))
    else $error("flags not cleared");
  AST_ANSWER: assert property (@(posedge clock_i) disable iff (!nrst_i)
    take |-> ##35 rsp_valid_o) else $error("answer late");
  COV_FULL_MOVE: cover property (@(posedge clock_i) disable iff (!nrst_i)
    state_ff == mddr_pkg::MS_DECEL ##1 state_ff == mddr_pkg::MS_CLEAN);
  COV_FAST_STOP: cover property (@(posedge clock_i) disable iff (!nrst_i)
    state_ff == mddr_pkg::MS_FAST);
  COV_AND: cover property (@(posedge clock_i) disable iff (!nrst_i)
    take && req_i.op == `MDDR_OP_AND);
  COV_FLAG_RACE: cover property (@(posedge clock_i) disable iff (!nrst_i)
    flg_wr && flag_event_i != 4'h0);
endmodule

// >>> design/mddr_cfg.svh
// register offsets, field positions, op codes and timing counts
// assumes a 50 MHz drive clock and 8-bit register indexes
`ifndef MDDR_CFG_SVH
`define MDDR_CFG_SVH
// user and accumulator registers, index 0 is the accumulator
`define MDDR_USER_FIRST 8'h00
`define MDDR_USER_LAST 8'h09
`define MDDR_USER_CNT 10
// read/write data registers
`define MDDR_ACCEL_RATE 8'h11
`define MDDR_DECEL_RATE 8'h12
`define MDDR_CHANGE_DIST 8'h13
`define MDDR_MOVE_DIST 8'h14
`define MDDR_POS_OFFSET 8'h15
`define MDDR_OTHER_FLAGS 8'h16
// read-only data registers
`define MDDR_MOVE_STATE 8'h3f
`define MDDR_SEGMENT 8'h40
`define MDDR_CURRENT 8'h41
`define MDDR_CLAMP_PWR 8'h42
`define MDDR_STATUS_CODE 8'h43
`define MDDR_TEMPERATURE 8'h44
`define MDDR_BUS_VOLT 8'h45
`define MDDR_ACT_VEL 8'h46
`define MDDR_TGT_VEL 8'h47
`define MDDR_POS_ERR 8'h48
`define MDDR_EXP_INPUTS 8'h49
`define MDDR_PHASE_ERR 8'h4a
// request op codes
`define MDDR_OP_READ 3'h0
`define MDDR_OP_WRITE 3'h1
`define MDDR_OP_AND 3'h2
`define MDDR_OP_ACCEL 3'h3
`define MDDR_OP_DECEL 3'h4
// expanded inputs layout
`define MDDR_EXP_IN_LSB 0
`define MDDR_EXP_OUT_LSB 8
`define MDDR_EXP_ID_BIT 15
// other flags bit positions
`define MDDR_FLG_DIST_LIMIT 0
`define MDDR_FLG_SENSOR 1
`define MDDR_FLG_LOW_OC 2
`define MDDR_FLG_HIGH_OC 3
`define MDDR_FLG_W 4
// command unit scale: register = 6 * rev/sec/sec
`define MDDR_ACC_SCALE 16'h0006
// move state codes
`define MDDR_MS_UNDEF 4'h0
`define MDDR_MS_WAIT 4'h1
`define MDDR_MS_CALC 4'h2
`define MDDR_MS_ACCEL 4'h3
`define MDDR_MS_CHANGE 4'h4
`define MDDR_MS_ATSPD 4'h5
`define MDDR_MS_DECEL 4'h6
`define MDDR_MS_FAST 4'h7
`define MDDR_MS_CLEAN 4'h8
// timing: one pwm cycle
`define MDDR_CLK_NS 20
`define MDDR_PWM_NS 62000
`define MDDR_PWM_CYC ((`MDDR_PWM_NS + `MDDR_CLK_NS - 1) / `MDDR_CLK_NS)
// decimal converter
`define MDDR_DIGITS 10
`define MDDR_CONV_STEPS 6'h20
`endif

// >>> design/mddr_pkg.sv
// types shared by the register bank, its host model and the testbench
// assumes mddr_cfg.svh for widths
package mddr_pkg;
  // host register request
  typedef struct packed {
    logic [2:0] op;      // op code
    logic [7:0] addr;    // target register
    logic [7:0] addr_b;  // second operand for and
    logic [31:0] data;   // write value or command value
  } mddr_req_t;
  // live values from the motion engine
  typedef struct packed {
    logic [15:0] segment;
    logic [15:0] current;
    logic [15:0] clamp_pwr;
    logic [15:0] status_code;
    logic [15:0] temperature;
    logic [15:0] bus_volt;
    logic [15:0] act_vel;
    logic [15:0] tgt_vel;
    logic [31:0] pos_err;
    logic [15:0] phase_err;
    logic [31:0] enc_pos;
  } mddr_status_t;
  // point-to-point move states, one-hot
  typedef enum logic [8:0] {
    MS_IDLE = 9'h001,
    MS_WAIT = 9'h002,
    MS_CALC = 9'h004,
    MS_ACCEL = 9'h008,
    MS_CHANGE = 9'h010,
    MS_ATSPD = 9'h020,
    MS_DECEL = 9'h040,
    MS_FAST = 9'h080,
    MS_CLEAN = 9'h100
  } mddr_move_t;
endpackage

// >>> design/mddr_bin2dec.sv
// signed binary to decimal digit converter, shift and add three
// assumes one start at a time; start is ignored while busy
`timescale 1ns/1ps
`include "mddr_cfg.svh"
module mddr_bin2dec (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // request
  input wire logic start_i,
  input wire logic [31:0] value_i,
  // answer
  output logic done_o,
  output logic neg_o,
  output logic [39:0] digits_o,
  output logic [31:0] value_o
);
  logic busy_ff;          // conversion running
  logic [5:0] step_ff;    // shifts left
  logic [31:0] bin_ff;    // magnitude being shifted out
  logic [39:0] bcd_ff;    // digits being built
  logic [39:0] adj;       // digits after add-three
  logic [31:0] mag;       // magnitude of the input

  assign mag = value_i[31] ? 32'h0 - value_i : value_i;

  // add three to every digit of five or more before the shift
  always_comb begin
    adj = bcd_ff;
    for (int i = 0; i < `MDDR_DIGITS; i++) begin
      if (bcd_ff[i*4 +: 4] > 4'h4) begin
        adj[i*4 +: 4] = bcd_ff[i*4 +: 4] + 4'h3;
      end
    end
  end

  // shift engine, done is a one-cycle pulse
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_ff <= 1'b0;
      step_ff <= 6'h00;
      bin_ff <= 32'h0;
      bcd_ff <= 40'h0;
      done_o <= 1'b0;
      neg_o <= 1'b0;
      digits_o <= 40'h0;
      value_o <= 32'h0;
    end else begin
      done_o <= 1'b0;
      if (!busy_ff && start_i) begin
        // capture operand
        busy_ff <= 1'b1;
        step_ff <= `MDDR_CONV_STEPS;
        bin_ff <= mag;
        bcd_ff <= 40'h0;
        neg_o <= value_i[31];
        value_o <= value_i;
      end else if (busy_ff && step_ff != 6'h00) begin
        // one shift per cycle
        bcd_ff <= {adj[38:0], bin_ff[31]};
        bin_ff <= {bin_ff[30:0], 1'b0};
        step_ff <= step_ff - 6'h01;
      end else if (busy_ff) begin
        // present result
        busy_ff <= 1'b0;
        digits_o <= bcd_ff;
        done_o <= 1'b1;
      end
    end
  end
endmodule

// >>> dv/mddr_host.sv
// host model: issues one register request at a time, waits for answer
// assumes answers come within 60 cycles of the take edge
`timescale 1ns/1ps
module mddr_host (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // bank handshake
  input wire logic req_ready_i,
  input wire logic rsp_valid_i,
  output logic req_valid_o,
  output mddr_pkg::mddr_req_t req_o
);
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
  // one request, a varied pause first, held until ready is sampled
  task automatic issue(input logic [2:0] op, input logic [7:0] a,
      input logic [7:0] b, input logic [31:0] d);
    int n;
    // zero would stall the drive, so accel and decel never get it
    if ((op > 3'h2 || (op == 3'h1 && (a == 8'h11 || a == 8'h12))) &&
        d == 32'h0) d = 32'h1;
    repeat (op) @(posedge clock_i);
    #2 req_valid_o = 1'b1;
    req_o = '{op, a, b, d};
    @(posedge clock_i);
    while (!req_ready_i) @(posedge clock_i);
    #2 req_valid_o = 1'b0;
    req_o = ~req_o;
    // answer is a one cycle pulse
    for (n = 0; n < 60 && !rsp_valid_i; n++) @(posedge clock_i) #1;
    repeat (2) @(posedge clock_i);
  endtask
endmodule

// >>> dv/testbench.sv
// self-checking bench for the register bank, host model on the port
// assumes answers within 60 cycles of take and a 3100 cycle cleanup
`timescale 1ns/1ps
module testbench;
  logic clock_i = 0, nrst_i = 0, rv, rdy, vld, err, neg, stp, stl, eb, spv;
  logic [39:0] dig;
  logic [31:0] val, sp, old;
  logic [7:0] top, mv, tb[12];
  logic [3:0] drv, fe, ms;
  mddr_pkg::mddr_req_t rq;
  mddr_pkg::mddr_status_t st;
  int err_total = 0, total_checks = 0, seed = 32'h282e, i, j;
  always #10 clock_i = ~clock_i;
  mddr_host mddr_host_i (.clock_i(clock_i), .nrst_i(nrst_i),
    .req_ready_i(rdy), .rsp_valid_i(vld), .req_valid_o(rv), .req_o(rq));
  mddr_regs mddr_regs_i (.clock_i(clock_i), .nrst_i(nrst_i),
    .req_valid_i(rv), .req_i(rq), .req_ready_o(rdy), .rsp_valid_o(vld),
    .rsp_err_o(err), .rsp_neg_o(neg), .rsp_digits_o(dig),
    .rsp_value_o(val), .stat_i(st), .stepper_i(stp), .stall_en_i(stl),
    .top_in_closed_i(top), .drv_out_closed_i(drv), .exp_board_i(eb),
    .set_pos_valid_i(spv), .set_pos_i(sp), .flag_event_i(fe),
    .move_start_i(mv[0]), .brake_released_i(mv[1]), .calc_done_i(mv[2]),
    .at_speed_i(mv[3]), .speed_change_i(mv[4]), .decel_start_i(mv[5]),
    .stop_i(mv[6]), .stopped_i(mv[7]), .accel_rate_o(),
    .decel_rate_o(), .change_dist_o(), .move_dist_o(), .move_state_o(ms));
  // compare one value, count it
  task automatic chk(string n, logic [39:0] e, logic [39:0] s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rd(logic [7:0] a);
    mddr_host_i.issue(3'h0, a, 8'h0, 32'h0);
  endtask
  // verdict and end of run
  task automatic finish_test;
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #1ms err_total++;
    finish_test();
  end
  initial begin
    {stp, stl, eb, spv, sp, top, drv, fe, mv} = '0;
    st = '0;
    // move steps as {input bit, expected code}
    tb = '{8'h01, 8'h12, 8'h23, 8'h35, 8'h44, 8'h67, 8'h78,
      8'h01, 8'h12, 8'h23, 8'h56, 8'h78};
    repeat (4) @(posedge clock_i);
    #2 nrst_i = 1;
    repeat (2) @(posedge clock_i);
    mddr_host_i.issue(3'h3, 8'h0, 8'h0, 32'd100);
    rd(8'h11);
    chk("accel", 32'd600, val);
    chk("digits", 40'h600, dig);
    j = ($random(seed) & 32'h3ff) + 1;
    mddr_host_i.issue(3'h4, 8'h0, 8'h0, j);
    rd(8'h12);
    chk("decel", j * 6, val);
    rd(8'h30);
    chk("unmapped", 1'b1, err);
    // mask register for the and
    mddr_host_i.issue(3'h1, 8'h01, 8'h0, 32'd4095);
    for (i = 0; i < 3; i++) begin
      #2 {top, drv, eb} = $random(seed);
      rd(8'h49);
      chk("expanded", {{16{eb}}, eb, 3'h0, ~drv, ~top}, val);
      mddr_host_i.issue(3'h2, 8'h49, 8'h01, 32'h0);
      rd(8'h00);
      chk("and", {20'h0, ~drv, ~top}, val);
    end
    // flags latch and clear
    mddr_host_i.issue(3'h1, 8'h16, 8'h0, 32'h0);
    i = $random(seed) & 3;
    j = i ^ 1;
    for (int k = 0; k < 2; k++) begin
      #2 fe = 4'h1 << (k ? j : i);
      @(posedge clock_i) #2 fe = 4'h0;
    end
    rd(8'h16);
    chk("flags", (32'h1 << i) | (32'h1 << j), val);
    mddr_host_i.issue(3'h1, 8'h16, 8'h0, 32'h0);
    rd(8'h16);
    chk("flags_clr", 32'h0, val);
    // distance registers read back what was written
    for (i = 8'h13; i < 8'h15; i++) begin
      old = $random(seed);
      mddr_host_i.issue(3'h1, 8'(i), 8'h0, old);
      rd(8'(i));
      chk("dist", old, val);
    end
    // position offset
    #2 st.enc_pos = $random(seed);
    sp = $random(seed);
    spv = 1;
    @(posedge clock_i) #2 spv = 0;
    repeat (2) @(posedge clock_i);
    old = st.enc_pos - sp;
    rd(8'h15);
    chk("offset", old, val);
    chk("offset_neg", old[31], neg);
    // target velocity with and without stall logic
    #2 st.tgt_vel = $random(seed);
    repeat (2) @(posedge clock_i);
    old = {{16{st.tgt_vel[15]}}, st.tgt_vel};
    rd(8'h47);
    chk("tgt_vel", old, val);
    #2 stp = 1;
    st.tgt_vel = ~st.tgt_vel;
    repeat (2) @(posedge clock_i);
    rd(8'h47);
    chk("tgt_hold", old, val);
    #2 stl = 1;
    repeat (2) @(posedge clock_i);
    rd(8'h47);
    chk("tgt_stall", {{16{st.tgt_vel[15]}}, st.tgt_vel}, val);
    // move state walk, cleanup length
    for (i = 0; i < 12; i++) begin
      @(posedge clock_i) #2 mv = 8'h1 << tb[i][7:4];
      @(posedge clock_i) #2 mv = 8'h0;
      chk("move_state", tb[i][3:0], ms);
      if (tb[i][3:0] == 4'h8) begin
        repeat (3099) @(posedge clock_i);
        #1 chk("clean_hold", 4'h8, ms);
        @(posedge clock_i) #1;
        chk("clean_end", 4'h0, ms);
      end
    end
    finish_test();
  end
endmodule
